// ### rtl/wbrc_pkg.sv
// constants shared by the watchdog and bidirectional reset control block
package wbrc_pkg;

  // ----------------------------------------------------------------
  // timing: one clock phase unit equals one reference clock period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_NS = 10;
  localparam int SEQ_PHASES = 1024;
  localparam int SAMPLE_PHASES = 8;
  localparam int SHORT_PHASES = 4;
  localparam int SEQ_CYC = (SEQ_PHASES * PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC = (SAMPLE_PHASES * PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC = (SHORT_PHASES * PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 11;

  // ----------------------------------------------------------------
  // configuration and port0 field layout
  // ----------------------------------------------------------------
  localparam int SYSCFG_BIDIR_BIT = 3;
  localparam int PORT0_KEEP_HI = 12;
  localparam int PORT0_KEEP_LO = 8;
  localparam int PORT0_SET_HI = 7;
  localparam int PORT0_SET_LO = 2;
  localparam logic [15:0] PORT0_RESET_VAL = 16'hffff;

  // ----------------------------------------------------------------
  // reset source and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WBRC_SRC_HW = 2'h0,
    WBRC_SRC_SW = 2'h1,
    WBRC_SRC_WDT = 2'h2
  } wbrc_src_t;

  typedef enum logic [6:0] {
    WBRC_RUN = 7'h01,
    WBRC_BUS = 7'h02,
    WBRC_SEQ = 7'h04,
    WBRC_POST = 7'h08,
    WBRC_LONG = 7'h10,
    WBRC_CHK = 7'h20,
    WBRC_ASYN = 7'h40
  } wbrc_state_t;

endpackage

// ### rtl/wbrc_seq_if.sv
// internal carrier between the sequencer, its phase timer and the watchdog
`timescale 1ns/1ns
`default_nettype none
interface wbrc_seq_if;
  import wbrc_pkg::*;
  logic ce;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_len;
  logic tmr_done;
  logic wdt_service;
  logic wdt_disable;
  logic wdt_rearm;
  logic wdt_ovf;

  modport ctl (
    output ce, tmr_load, tmr_len, wdt_service, wdt_disable, wdt_rearm,
    input tmr_done, wdt_ovf
  );
  modport tmr (input ce, tmr_load, tmr_len, output tmr_done);
  modport wdt (input ce, wdt_service, wdt_disable, wdt_rearm, output wdt_ovf);
endinterface
`default_nettype wire

// ### rtl/wbrc_tmr.sv
// phase timer: counts a loaded number of clock phase units, then pulses done
`timescale 1ns/1ns
`default_nettype none
module wbrc_tmr
  import wbrc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  wbrc_seq_if.tmr bus
);

  logic [TMR_W-1:0] cnt_q, cnt_d;

  // -------------------------------------------------------------
  // next count; a reload restarts the period at once
  // -------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (bus.tmr_load) begin
      cnt_d = bus.tmr_len;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // registers frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (bus.ce) begin
      cnt_q <= cnt_d;
    end
  end

  // done shows in the last counted cycle, so a period of n ends exactly n edges after the load
  assign bus.tmr_done = bus.ce & (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

// ### rtl/wbrc_top.sv
// reset sequencer with watchdog entry, bidirectional reset pin and source flags
`timescale 1ns/1ns
`default_nettype none
module wbrc_top
  import wbrc_pkg::*;
#(
  parameter int WDT_W = 16
) (
  // clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CLK_EN_I,
  // reset pins (filtered reset input is active low)
  input wire logic FILTERED_RESET_INPUT_N_I,
  input wire logic POWERDOWN_RESET_PIN_I,
  output logic RESET_INPUT_PIN_O,
  output logic RESET_INPUT_PIN_OE_O,
  output logic RESET_OUTPUT_PIN_N_O,
  output logic PD_PULLUP_O,
  output logic PD_PULLDOWN_O,
  output logic INTERNAL_RESET_O,
  // software events
  input wire logic SW_RESET_I,
  input wire logic END_OF_INIT_I,
  input wire logic WDT_SERVICE_I,
  input wire logic WDT_DISABLE_I,
  // configuration bits
  input wire logic BIDIR_EN_WR_I,
  input wire logic BIDIR_EN_WDATA_I,
  input wire logic POWERDOWN_PULLUP_CONFIG_I,
  output logic BIDIR_RESET_ENABLE_O,
  // external bus cycle in flight
  input wire logic BUS_CYCLE_ACTIVE_I,
  input wire logic BUS_USES_READY_I,
  input wire logic BUS_WAIT_DONE_I,
  input wire logic BUS_READY_N_I,
  output logic BUS_ABORT_O,
  // port0 configuration latch
  input wire logic [15:0] PORT0_I,
  output logic [15:0] PORT0_LATCH_O,
  // source flags
  input wire logic FLAG_CLR_I,
  output logic FLAG_HW_O,
  output logic FLAG_SW_O,
  output logic FLAG_WDT_O,
  output logic FLAG_LONG_O,
  output logic FLAG_ASYNC_O
);

  // -------------------------------------------------------------
  // helper blocks
  // -------------------------------------------------------------
  wbrc_seq_if sif ();

  wbrc_tmr u_tmr (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .bus(sif.tmr)
  );

  wbrc_wdt #(.WDT_W(WDT_W)) u_wdt (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .bus(sif.wdt)
  );

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  wbrc_state_t st_q, st_d;
  wbrc_src_t src_q, src_d;
  logic bidir_q, bidir_d;     // software copy of the enable bit
  logic act_q, act_d;         // enable captured for the running sequence
  logic drive_q, drive_d;     // open drain active on the reset pin
  logic init_done_q, init_done_d;
  logic rout_n_q, rout_n_d;
  logic pullup_q, pullup_d;
  logic pulldn_q, pulldn_d;
  logic abort_q, abort_d;
  logic [15:0] port0_q, port0_d;
  logic irst_q, irst_d;       // internal reset, registered for the output
  logic f_hw_q, f_hw_d, f_sw_q, f_sw_d, f_wdt_q, f_wdt_d;
  logic f_long_q, f_long_d, f_async_q, f_async_d;
  logic rst_low;
  logic start;
  wbrc_src_t start_src;

  assign rst_low = ~FILTERED_RESET_INPUT_N_I;
  assign sif.ce = CLK_EN_I;
  assign sif.wdt_service = WDT_SERVICE_I;
  assign sif.wdt_disable = WDT_DISABLE_I & ~init_done_q;
  assign sif.wdt_rearm = start;

  // -------------------------------------------------------------
  // sequencer next state
  // -------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    src_d = src_q;
    act_d = act_q;
    drive_d = drive_q;
    init_done_d = init_done_q;
    rout_n_d = rout_n_q;
    pullup_d = pullup_q;
    abort_d = 1'b0;
    port0_d = port0_q;
    f_hw_d = f_hw_q & ~FLAG_CLR_I;
    f_sw_d = f_sw_q & ~FLAG_CLR_I;
    f_wdt_d = f_wdt_q & ~FLAG_CLR_I;
    f_long_d = f_long_q & ~FLAG_CLR_I;
    f_async_d = f_async_q & ~FLAG_CLR_I;
    bidir_d = bidir_q;
    start = 1'b0;
    start_src = WBRC_SRC_HW;
    sif.tmr_load = 1'b0;
    sif.tmr_len = TMR_W'(SEQ_CYC);

    // software writes the enable only while initialisation is open
    if (BIDIR_EN_WR_I && !init_done_q && st_q == WBRC_RUN) begin
      bidir_d = BIDIR_EN_WDATA_I;
    end
    // end of init releases the reset output
    if (END_OF_INIT_I && st_q == WBRC_RUN && !init_done_q) begin
      init_done_d = 1'b1;
      rout_n_d = 1'b1;
    end

    case (st_q)
      WBRC_RUN: begin
        if (rst_low) begin
          start = 1'b1;
          start_src = WBRC_SRC_HW;
        end else if (SW_RESET_I) begin
          start = 1'b1;
          start_src = WBRC_SRC_SW;
        end else if (sif.wdt_ovf) begin
          if (BUS_CYCLE_ACTIVE_I) begin
            st_d = WBRC_BUS;
          end else begin
            start = 1'b1;
            start_src = WBRC_SRC_WDT;
          end
        end
      end
      WBRC_BUS: begin
        // cycles without READY, or READY low after wait states, finish normally
        if (!BUS_CYCLE_ACTIVE_I) begin
          start = 1'b1;
          start_src = WBRC_SRC_WDT;
        end else if (BUS_USES_READY_I && BUS_WAIT_DONE_I && BUS_READY_N_I) begin
          abort_d = 1'b1;
          start = 1'b1;
          start_src = WBRC_SRC_WDT;
        end
      end
      WBRC_SEQ: begin
        if (src_q == WBRC_SRC_HW && rst_low && !POWERDOWN_RESET_PIN_I) begin
          st_d = WBRC_ASYN;
          f_async_d = 1'b1;
        end else if (src_q != WBRC_SRC_HW && !POWERDOWN_RESET_PIN_I) begin
          drive_d = 1'b0;
        end
        if (sif.tmr_done) begin
          drive_d = 1'b0;
          if (POWERDOWN_PULLUP_CONFIG_I) begin
            pullup_d = 1'b1;
          end
          if (src_q == WBRC_SRC_HW) begin
            st_d = WBRC_POST;
            sif.tmr_load = 1'b1;
            sif.tmr_len = TMR_W'(SAMPLE_CYC);
          end else begin
            // port0 upper config bits kept, lower ones forced high
            port0_d[PORT0_KEEP_HI:PORT0_KEEP_LO] = PORT0_I[PORT0_KEEP_HI:PORT0_KEEP_LO];
            port0_d[PORT0_SET_HI:PORT0_SET_LO] = '1;
            st_d = act_q ? WBRC_CHK : WBRC_RUN;
            sif.tmr_load = act_q;
            sif.tmr_len = TMR_W'(SHORT_CYC);
          end
        end
      end
      WBRC_POST: begin
        if (sif.tmr_done) begin
          if (rst_low) begin
            st_d = WBRC_LONG;
            f_long_d = 1'b1;
          end else begin
            port0_d = PORT0_I;
            st_d = WBRC_RUN;
          end
        end
      end
      WBRC_LONG, WBRC_ASYN: begin
        // held until the filtered input rises again
        if (!rst_low) begin
          port0_d = PORT0_I;
          if (POWERDOWN_PULLUP_CONFIG_I) begin
            pullup_d = 1'b1;
          end
          drive_d = 1'b0;
          st_d = WBRC_RUN;
        end
      end
      WBRC_CHK: begin
        // device already runs; a lingering low turns into a hardware reset
        if (!rst_low) begin
          st_d = WBRC_RUN;
        end else if (sif.tmr_done) begin
          start = 1'b1;
          start_src = WBRC_SRC_HW;
        end
      end
      default: begin
        st_d = WBRC_RUN;
      end
    endcase

    // common entry into the internal sequence
    if (start) begin
      st_d = WBRC_SEQ;
      src_d = start_src;
      sif.tmr_load = 1'b1;
      sif.tmr_len = TMR_W'(SEQ_CYC);
      act_d = bidir_q | (act_q & st_q == WBRC_CHK);
      bidir_d = 1'b0;
      // software and watchdog drive only with powerdown pin high
      drive_d = (bidir_q | (act_q & st_q == WBRC_CHK)) &
                (start_src == WBRC_SRC_HW | POWERDOWN_RESET_PIN_I);
      if (start_src == WBRC_SRC_HW && !POWERDOWN_RESET_PIN_I) begin
        st_d = WBRC_ASYN;
        f_async_d = 1'b1;
      end
      init_done_d = 1'b0;
      rout_n_d = 1'b0;
      pullup_d = 1'b0;
      // latest source replaces older ones, set wins over clear
      f_hw_d = (start_src == WBRC_SRC_HW);
      f_sw_d = (start_src == WBRC_SRC_SW);
      f_wdt_d = (start_src == WBRC_SRC_WDT);
      f_long_d = 1'b0;
      f_async_d = (start_src == WBRC_SRC_HW) & ~POWERDOWN_RESET_PIN_I;
    end

    // pulldown follows the reset pin level, ours or the outside driver's
    pulldn_d = rst_low | drive_d;
    // internal reset spans the sequence and every held state after it
    irst_d = (st_d == WBRC_SEQ) | (st_d == WBRC_POST) |
             (st_d == WBRC_LONG) | (st_d == WBRC_ASYN);
  end

  // -------------------------------------------------------------
  // registers; all state frozen while the clock enable is low
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= WBRC_RUN;
      src_q <= WBRC_SRC_HW;
      bidir_q <= 1'b0;
      act_q <= 1'b0;
      drive_q <= 1'b0;
      init_done_q <= 1'b0;
      rout_n_q <= 1'b0;
      pullup_q <= 1'b0;
      pulldn_q <= 1'b0;
      abort_q <= 1'b0;
      port0_q <= PORT0_RESET_VAL;
      irst_q <= 1'b0;
      f_hw_q <= 1'b1;
      f_sw_q <= 1'b0;
      f_wdt_q <= 1'b0;
      f_long_q <= 1'b0;
      f_async_q <= 1'b0;
    end else if (CLK_EN_I) begin
      st_q <= st_d;
      src_q <= src_d;
      bidir_q <= bidir_d;
      act_q <= act_d;
      drive_q <= drive_d;
      init_done_q <= init_done_d;
      rout_n_q <= rout_n_d;
      pullup_q <= pullup_d;
      pulldn_q <= pulldn_d;
      abort_q <= abort_d;
      port0_q <= port0_d;
      irst_q <= irst_d;
      f_hw_q <= f_hw_d;
      f_sw_q <= f_sw_d;
      f_wdt_q <= f_wdt_d;
      f_long_q <= f_long_d;
      f_async_q <= f_async_d;
    end
  end

  // -------------------------------------------------------------
  // outputs, all from flip-flops except the constant RESET_INPUT_PIN_O
  // -------------------------------------------------------------
  assign RESET_INPUT_PIN_O = 1'b0; // open drain only ever pulls low
  assign RESET_INPUT_PIN_OE_O = drive_q;
  assign RESET_OUTPUT_PIN_N_O = rout_n_q;
  assign PD_PULLUP_O = pullup_q;
  assign PD_PULLDOWN_O = pulldn_q;
  assign INTERNAL_RESET_O = irst_q;
  assign BIDIR_RESET_ENABLE_O = bidir_q;
  assign BUS_ABORT_O = abort_q;
  assign PORT0_LATCH_O = port0_q;
  assign FLAG_HW_O = f_hw_q;
  assign FLAG_SW_O = f_sw_q;
  assign FLAG_WDT_O = f_wdt_q;
  assign FLAG_LONG_O = f_long_q;
  assign FLAG_ASYNC_O = f_async_q;

endmodule
`default_nettype wire

// ### rtl/wbrc_wdt.sv
// watchdog counter: overflows unless disabled early or serviced in time
`timescale 1ns/1ns
`default_nettype none
module wbrc_wdt
  import wbrc_pkg::*;
#(
  parameter int WDT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  wbrc_seq_if.wdt bus
);

  logic [WDT_W-1:0] cnt_q, cnt_d;
  logic off_q, off_d;
  logic ovf_q, ovf_d;

  // -------------------------------------------------------------
  // count up; a reset sequence rearms the dog and zeroes the count
  // -------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    off_d = off_q;
    ovf_d = 1'b0;
    if (bus.wdt_rearm) begin
      cnt_d = '0;
      off_d = 1'b0;
    end else if (bus.wdt_disable) begin
      off_d = 1'b1;
    end else if (bus.wdt_service) begin
      cnt_d = '0;
    end else if (!off_q) begin
      cnt_d = cnt_q + 1'b1;
      ovf_d = (cnt_q == '1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      off_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (bus.ce) begin
      cnt_q <= cnt_d;
      off_q <= off_d;
      ovf_q <= ovf_d;
    end
  end

  assign bus.wdt_ovf = ovf_q & bus.ce;

endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the watchdog and bidirectional reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, sw = 1'b0, ei = 1'b0, svc = 1'b0, svc_on = 1'b1;
  logic bwr = 1'b0, bwd = 1'b0, pcfg = 1'b1, ba = 1'b0, bu = 1'b0, bw = 1'b0, brn = 1'b0;
  logic btn = 1'b0, pdl = 1'b0, wdis = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [15:0] port0 = 16'h0000;
  logic [15:0] p0l;
  logic fin_n, pd, oe, od, rso_n, pu, pdn, irst, ben, abt, fhw, fsw, fwd, flg, fas;
  int cyc = 0, n_abt = 0, i = 0, k = 0, miscompares = 0, cmp_count = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // short watchdog so an overflow takes 256 cycles
  wbrc_top #(.WDT_W(8)) i_dut (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(1'b1),
    .FILTERED_RESET_INPUT_N_I(fin_n), .POWERDOWN_RESET_PIN_I(pd),
    .RESET_INPUT_PIN_O(od), .RESET_INPUT_PIN_OE_O(oe), .RESET_OUTPUT_PIN_N_O(rso_n),
    .PD_PULLUP_O(pu), .PD_PULLDOWN_O(pdn), .INTERNAL_RESET_O(irst),
    .SW_RESET_I(sw), .END_OF_INIT_I(ei), .WDT_SERVICE_I(svc), .WDT_DISABLE_I(wdis),
    .BIDIR_EN_WR_I(bwr), .BIDIR_EN_WDATA_I(bwd), .POWERDOWN_PULLUP_CONFIG_I(pcfg),
    .BIDIR_RESET_ENABLE_O(ben), .BUS_CYCLE_ACTIVE_I(ba), .BUS_USES_READY_I(bu),
    .BUS_WAIT_DONE_I(bw), .BUS_READY_N_I(brn), .BUS_ABORT_O(abt),
    .PORT0_I(port0), .PORT0_LATCH_O(p0l), .FLAG_CLR_I(1'b0), .FLAG_HW_O(fhw),
    .FLAG_SW_O(fsw), .FLAG_WDT_O(fwd), .FLAG_LONG_O(flg), .FLAG_ASYNC_O(fas)
  );
  // far side of the reset pins
  wbrc_ext i_ext (
    .clk_i(clk), .pin_oe_i(oe), .pin_o_i(od), .rst_f_n_o(fin_n), .pd_o(pd),
    .btn_i(btn), .pd_low_i(pdl), .dly_i(dly)
  );

  // ----------------------------------------------------------------
  // background service, abort counting, time limit
  // ----------------------------------------------------------------
  // service every 32 cycles keeps the watchdog well short of overflow
  always @(posedge clk) begin
    cyc <= cyc + 1;
    svc <= svc_on && (cyc[4:0] == 5'h00);
    if (abt === 1'b1) n_abt <= n_abt + 1;
  end
  // about eight sequences of some 1100 cycles each, with ample margin
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // waits for internal reset to reach a level, bounded by a full sequence and more
  task wait_lvl(input logic v);
    i = 0;
    while (irst !== v && i < 3000) begin
      tick(1);
      i++;
    end
    chk(irst, v);
  endtask
  task wr_bidir(input logic b);
    @(posedge clk) bwd <= b;
    @(posedge clk) bwr <= 1'b1;
    @(posedge clk) bwr <= 1'b0;
    tick(1);
  endtask
  task init(input logic b);
    chk(rso_n, 1'b0);
    wr_bidir(b);
    chk(ben, b);
    @(posedge clk) ei <= 1'b1;
    @(posedge clk) ei <= 1'b0;
    tick(1);
    chk(rso_n, 1'b1);
  endtask
  task sw_pulse;
    @(posedge clk) sw <= 1'b1;
    @(posedge clk) sw <= 1'b0;
    tick(1);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(p0l, 16'hffff);
    init(1'b1);
    wr_bidir(1'b0);
    chk(ben, 1'b1);
    $display("test config done");
    // software reset with the pin driven
    sw_pulse();
    chk(irst, 1'b1);
    chk(oe, 1'b1);
    chk(od, 1'b0);
    chk(rso_n, 1'b0);
    chk(ben, 1'b0);
    chk(pu, 1'b0);
    tick(1);
    chk(pdn, 1'b1);
    wait_lvl(1'b0);
    tick(12);
    chk(p0l, 16'he0ff);
    chk(fhw, 1'b0);
    chk(pu, 1'b1);
    $display("test software done");
    // watchdog overflow aborts a ready cycle, powerdown pin low
    init(1'b1);
    @(posedge clk) port0 <= 16'h1234;
    @(posedge clk) pdl <= 1'b1;
    @(posedge clk) bu <= 1'b1;
    @(posedge clk) bw <= 1'b1;
    @(posedge clk) brn <= 1'b1;
    @(posedge clk) ba <= 1'b1;
    @(posedge clk) svc_on <= 1'b0;
    for (k = 0; k < 400 && n_abt == 0; k++) tick(1);
    chk(n_abt, 1);
    wait_lvl(1'b1);
    chk(oe, 1'b0);
    chk(fwd, 1'b1);
    chk(fas, 1'b0);
    @(posedge clk) svc_on <= 1'b1;
    @(posedge clk) ba <= 1'b0;
    wait_lvl(1'b0);
    @(posedge clk) pdl <= 1'b0;
    tick(12);
    chk(p0l, 16'hf2ff);
    $display("test watchdog abort done");
    // watchdog with a cycle that ignores ready, then powerdown drops mid-sequence
    init(1'b1);
    @(posedge clk) bu <= 1'b0;
    @(posedge clk) ba <= 1'b1;
    @(posedge clk) svc_on <= 1'b0;
    tick(300);
    @(posedge clk) svc_on <= 1'b1;
    @(posedge clk) ba <= 1'b0;
    wait_lvl(1'b1);
    chk(n_abt, 1);
    chk(oe, 1'b1);
    tick(100);
    @(posedge clk) pdl <= 1'b1;
    tick(3);
    chk(oe, 1'b0);
    chk(irst, 1'b1);
    wait_lvl(1'b0);
    @(posedge clk) pdl <= 1'b0;
    tick(12);
    $display("test watchdog complete done");
    // pin held low past a software reset degenerates to hardware
    init(1'b1);
    sw_pulse();
    tick(5);
    @(posedge clk) btn <= 1'b1;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk(fhw, 1'b1);
    chk(fsw, 1'b0);
    @(posedge clk) btn <= 1'b0;
    wait_lvl(1'b0);
    tick(20);
    $display("test degenerate done");
    // hardware bidir reset: fast filter gives short, slow filter gives long
    for (k = 0; k < 2; k++) begin
      init(1'b1);
      @(posedge clk) dly <= (k == 1) ? 4'hc : 4'h0;
      @(posedge clk) btn <= 1'b1;
      wait_lvl(1'b1);
      chk(oe, 1'b1);
      @(posedge clk) btn <= 1'b0;
      wait_lvl(1'b0);
      tick(20);
      chk(flg, k[0]);
    end
    @(posedge clk) dly <= 4'h0;
    $display("test short long done");
    // hardware reset with powerdown pin low goes asynchronous
    @(posedge clk) pcfg <= 1'b0;
    @(posedge clk) pdl <= 1'b1;
    @(posedge clk) btn <= 1'b1;
    wait_lvl(1'b1);
    chk(fas, 1'b1);
    chk(pdn, 1'b1);
    // hold the button for a full sequence so the run-length check sees a complete one
    tick(1100);
    @(posedge clk) btn <= 1'b0;
    @(posedge clk) pdl <= 1'b0;
    wait_lvl(1'b0);
    tick(20);
    chk(pu, 1'b0);
    $display("test asynchronous done");
    // watchdog disabled during init never bites; late enable writes are refused
    @(posedge clk) wdis <= 1'b1;
    @(posedge clk) wdis <= 1'b0;
    @(posedge clk) svc_on <= 1'b0;
    tick(300);
    chk(irst, 1'b0);
    chk(fhw, 1'b1);
    init(1'b0);
    wr_bidir(1'b1);
    chk(ben, 1'b0);
    $display("test disable lock done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### testbench/wbrc_ext.sv
// external reset network: pin pull-up, push button, input filter, powerdown capacitor
`timescale 1ns/1ns
`default_nettype none
module wbrc_ext (
  // clock
  input wire logic clk_i,
  // device side
  input wire logic pin_oe_i,
  input wire logic pin_o_i,
  output logic rst_f_n_o,
  output logic pd_o,
  // bench control
  input wire logic btn_i,
  input wire logic pd_low_i,
  input wire logic [3:0] dly_i
);
  logic pin_n;
  logic [15:0] sh_d;
  logic [15:0] sh_q = 16'hffff;
  // wired-and pin: pull-up wins unless the button or the open drain pulls low
  assign pin_n = !(btn_i || (pin_oe_i && !pin_o_i));
  // filter lag is adjustable so a slow release can straddle the sample point
  assign sh_d = {sh_q[14:0], pin_n};
  always_ff @(posedge clk_i) sh_q <= sh_d;
  assign rst_f_n_o = sh_q[dly_i];
  // capacitor kept charged by the external resistor unless discharged on purpose
  assign pd_o = !pd_low_i;
endmodule
`default_nettype wire

// ### testbench/wbrc_sva.sv
// port-level assertions for the reset sequencer, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module wbrc_sva
  import wbrc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // inputs
  input wire logic FILTERED_RESET_INPUT_N_I,
  input wire logic POWERDOWN_RESET_PIN_I,
  input wire logic POWERDOWN_PULLUP_CONFIG_I,
  input wire logic BIDIR_EN_WR_I,
  input wire logic END_OF_INIT_I,
  // outputs
  input wire logic RESET_INPUT_PIN_OE_O,
  input wire logic RESET_OUTPUT_PIN_N_O,
  input wire logic PD_PULLUP_O,
  input wire logic PD_PULLDOWN_O,
  input wire logic INTERNAL_RESET_O,
  input wire logic BIDIR_RESET_ENABLE_O,
  input wire logic BUS_ABORT_O,
  input wire logic [15:0] PORT0_LATCH_O,
  input wire logic FLAG_HW_O,
  input wire logic FLAG_WDT_O,
  input wire logic FLAG_ASYNC_O
);
  // ----------------------------------------------------------------
  // run-length counters
  // ----------------------------------------------------------------
  localparam int LEN_LO = SEQ_CYC - 1;
  localparam int LEN_HI = SEQ_CYC + 1;
  logic [15:0] oe_cnt_d, oe_cnt_q, ir_cnt_d, ir_cnt_q;
  // one cycle of slack either way, since the timer load edge may or may not count
  always_comb begin
    oe_cnt_d = (RESET_INPUT_PIN_OE_O && !SYS_RST_I) ? oe_cnt_q + 16'h0001 : 16'h0000;
    ir_cnt_d = (INTERNAL_RESET_O && !SYS_RST_I) ? ir_cnt_q + 16'h0001 : 16'h0000;
  end
  // counter registers
  always_ff @(posedge REF_CLK_I) begin
    oe_cnt_q <= oe_cnt_d;
    ir_cnt_q <= ir_cnt_d;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_reset_output_pin_start: assert property ($rose(INTERNAL_RESET_O) |-> !RESET_OUTPUT_PIN_N_O)
    else $error("reset output not low at sequence start");
  a_reset_output_pin_rel: assert property ($rose(RESET_OUTPUT_PIN_N_O) |-> $past(END_OF_INIT_I))
    else $error("reset output released without end of init");
  a_bidir_clr: assert property ($rose(INTERNAL_RESET_O) |-> !BIDIR_RESET_ENABLE_O)
    else $error("bidir enable survived a reset start");
  a_bidir_lock: assert property (RESET_OUTPUT_PIN_N_O && BIDIR_EN_WR_I && !BIDIR_RESET_ENABLE_O
    |=> !BIDIR_RESET_ENABLE_O)
    else $error("bidir enable set after end of init");
  a_drive_len: assert property ($fell(RESET_INPUT_PIN_OE_O) && POWERDOWN_RESET_PIN_I
    |-> oe_cnt_q >= LEN_LO && oe_cnt_q <= LEN_HI)
    else $error("reset pin drive length wrong");
  a_pulldn_on: assert property ((RESET_INPUT_PIN_OE_O || !$past(FILTERED_RESET_INPUT_N_I))
    |-> PD_PULLDOWN_O)
    else $error("pulldown off while reset pin low");
  a_abort_seq: assert property (BUS_ABORT_O |-> ##[0:2] INTERNAL_RESET_O)
    else $error("no reset sequence after bus abort");
  a_wdt_sync: assert property ($rose(INTERNAL_RESET_O) && FLAG_WDT_O |-> !FLAG_ASYNC_O)
    else $error("watchdog reset taken as asynchronous");
  a_seq_len: assert property ($fell(INTERNAL_RESET_O) |-> ir_cnt_q >= LEN_LO)
    else $error("internal reset shorter than the sequence");
  a_port0_set: assert property ($fell(INTERNAL_RESET_O) && !FLAG_HW_O
    |-> ##[0:1] PORT0_LATCH_O[7:2] == 6'h3f)
    else $error("port0 low field not forced high");
  a_pullup_end: assert property ($fell(INTERNAL_RESET_O) && POWERDOWN_PULLUP_CONFIG_I
    |-> ##[0:1] PD_PULLUP_O)
    else $error("pullup not enabled at sequence end");
  c_abort: cover property ($rose(BUS_ABORT_O));
  c_async: cover property ($rose(FLAG_ASYNC_O));
  c_early: cover property ($fell(RESET_INPUT_PIN_OE_O) && !POWERDOWN_RESET_PIN_I);
endmodule
bind wbrc_top wbrc_sva i_sva (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
  .FILTERED_RESET_INPUT_N_I(FILTERED_RESET_INPUT_N_I),
  .POWERDOWN_RESET_PIN_I(POWERDOWN_RESET_PIN_I),
  .POWERDOWN_PULLUP_CONFIG_I(POWERDOWN_PULLUP_CONFIG_I),
  .BIDIR_EN_WR_I(BIDIR_EN_WR_I), .END_OF_INIT_I(END_OF_INIT_I),
  .RESET_INPUT_PIN_OE_O(RESET_INPUT_PIN_OE_O), .RESET_OUTPUT_PIN_N_O(RESET_OUTPUT_PIN_N_O),
  .PD_PULLUP_O(PD_PULLUP_O), .PD_PULLDOWN_O(PD_PULLDOWN_O),
  .INTERNAL_RESET_O(INTERNAL_RESET_O), .BIDIR_RESET_ENABLE_O(BIDIR_RESET_ENABLE_O),
  .BUS_ABORT_O(BUS_ABORT_O), .PORT0_LATCH_O(PORT0_LATCH_O), .FLAG_HW_O(FLAG_HW_O),
  .FLAG_WDT_O(FLAG_WDT_O), .FLAG_ASYNC_O(FLAG_ASYNC_O)
);
`default_nettype wire
